/* File: swm_params.svh */
// offsets, field positions, reset values and constants of the syn wake / arp matcher
`ifndef SWM_PARAMS_SVH
`define SWM_PARAMS_SVH

// --------------------
// register byte offsets
// --------------------
`define SWM_OFF_DEST0    12'h6AC
`define SWM_OFF_DEST3    12'h6B8
`define SWM_OFF_PORTS    12'h6BC
`define SWM_OFF_ARP_SENDER_IP_MATCH  12'h6C0
`define SWM_OFF_ARP_TARGET_IP_MATCH  12'h6C4
`define SWM_OFF_CTRL     12'h6C8
`define SWM_OFF_STATUS   12'h6CC
`define SWM_OFF_MASK     12'h6D0
`define SWM_OFF_PHY_ID   12'h700

// --------------------
// field positions and reset values
// --------------------
`define SWM_CTRL_V6_WAKE 0
`define SWM_CTRL_ARP_EN  1
`define SWM_EVT_WAKE     0
`define SWM_EVT_ARP      1
`define SWM_PORT_DST_HI  31
`define SWM_PORT_DST_LO  16
`define SWM_PORT_SRC_HI  15
`define SWM_PORT_SRC_LO  0
`define SWM_RESET_WORD   32'h0000_0000
`define SWM_RESET_BITS   2'h0

// --------------------
// frame constants
// --------------------
`define SWM_ETYPE_ARP    16'h0806
`define SWM_ETYPE_IPV6   16'h86DD
`define SWM_NEXT_HDR_TCP 8'h06
`define SWM_BCAST_MAC    48'hFFFF_FFFF_FFFF
`define SWM_MCAST_BIT    40

`endif

/* File: swm_pkg.sv */
// types shared by the syn wake / arp matcher
package swm_pkg;

    // complete state of the matcher
    typedef struct packed {
        logic [3:0][31:0] dest;     // ipv6 destination match words
        logic [31:0]      ports;    // v6_syn_port_pair
        logic [31:0]      spa;      // arp_sender_ip_match
        logic [31:0]      tpa;      // arp_target_ip_match
        logic [1:0]       ctrl;     // enables
        logic [1:0]       status;   // sticky events
        logic [1:0]       mask;     // interrupt mask
        logic             waitreq;  // bus waitrequest
        logic [31:0]      rdata;    // bus read data
        logic             wake;     // wake pulse
        logic             arp;      // arp response pulse
        logic             irq;      // interrupt level
    } swm_state_s;

endpackage

/* File: swm_syn_wake_arp_match.sv */
// ipv6 syn wake and arp offload matcher with avalon registers
//
// Contract
// RULE_01: dest compare only with v6 wake on, in first or third suspend.
// RULE_02: port compare only with v6 wake on, in first suspend.
// RULE_03: a syn frame must go to our mac, a multicast or broadcast.
// RULE_04: only valid tcp segments with syn set count.
// RULE_05: addresses compare with those in the ipv6 headers.
// RULE_06: wake needs both addresses and both ports to match.
// RULE_07: dest value is four words, lowest offset bits 31:0.
// RULE_08: an all-zero address value always matches.
// RULE_09: port word is dest 31:16, source 15:0, zero matches all.
// RULE_10: with arp offload on, only type 0806h is an arp candidate.
// RULE_11: an arp candidate must go to our mac or broadcast.
// RULE_12: programmed sender and target addresses compare with spa and tpa.
// RULE_13: both matching with no receive error send an arp response.
// RULE_14: a zero arp address register always matches.
// RULE_15: the phy id word is read-only revision, model and oui bits.
// RULE_16: ipv4 addresses keep the first received byte in 31:24.
// RULE_17: a syn match gives one wake pulse, none for bad frames.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`include "swm_params.svh"

module swm_syn_wake_arp_match
    import swm_pkg::*;
#(
    parameter logic [3:0]  PHY_REVISION = 4'h1,          // arbitrary value
    parameter logic [5:0]  PHY_MODEL    = 6'h2A,         // arbitrary value
    parameter logic [21:0] PHY_OUI_BITS = 22'h0A_BCDE    // arbitrary value
) (
    input  wire logic         clk_sys_in,
    input  wire logic         reset_in,
    input  wire logic [11:0]  avs_address_in,
    input  wire logic         avs_read_in,
    input  wire logic         avs_write_in,
    input  wire logic [31:0]  avs_writedata_in,
    input  wire logic [3:0]   avs_byteenable_in,
    output logic      [31:0]  avs_readdata_out,
    output logic              avs_waitrequest_out,
    input  wire logic [47:0]  station_mac_in,
    input  wire logic         first_suspend_state_in,
    input  wire logic         third_suspend_state_in,
    input  wire logic [127:0] v6_syn_source_match_in,
    input  wire logic         rx_frame_done_in,
    input  wire logic         rx_frame_error_in,
    input  wire logic [47:0]  rx_dest_mac_in,
    input  wire logic [15:0]  rx_ethertype_in,
    input  wire logic [7:0]   rx_ipv6_next_hdr_in,
    input  wire logic [127:0] rx_ipv6_src_in,
    input  wire logic [127:0] rx_ipv6_dst_in,
    input  wire logic [15:0]  rx_tcp_src_port_in,
    input  wire logic [15:0]  rx_tcp_dst_port_in,
    input  wire logic         rx_tcp_syn_in,
    input  wire logic         rx_tcp_valid_in,
    input  wire logic [31:0]  rx_arp_sender_ip_match_in,
    input  wire logic [31:0]  rx_arp_target_ip_match_in,
    output logic              wake_event_out,
    output logic              arp_respond_out,
    output logic              irq_out
);

    // --------------------
    // helpers
    // --------------------

    // zero programmed value is a wildcard, otherwise exact compare
    function automatic logic wild_match(input logic [127:0] prog, input logic [127:0] seen);
        return (prog == 128'h0) || (prog == seen);
    endfunction

    // merge write data into a word under byte enables
    function automatic logic [31:0] apply_be(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction

    swm_state_s st_q;
    swm_state_s st_d;

    logic        bus_req;
    logic        bus_take;
    logic        da_own;
    logic        da_bcast;
    logic        da_mcast;
    logic        v6_active;
    logic        port_active;
    logic        v6_frame_ok;
    logic        dst_ok;
    logic        src_ok;
    logic        ports_ok;
    logic        wake_hit;
    logic        arp_frame_ok;
    logic        arp_addr_ok;
    logic        arp_hit;
    logic [31:0] phy_id_word;

    // --------------------
    // frame classification
    // --------------------

    // destination mac classes
    assign da_own   = (rx_dest_mac_in == station_mac_in);
    assign da_bcast = (rx_dest_mac_in == `SWM_BCAST_MAC);
    assign da_mcast = rx_dest_mac_in[`SWM_MCAST_BIT];

    // RULE_01 address compare window
    assign v6_active   = st_q.ctrl[`SWM_CTRL_V6_WAKE]
                         && (first_suspend_state_in || third_suspend_state_in);
    // RULE_02 port compare window
    assign port_active = st_q.ctrl[`SWM_CTRL_V6_WAKE] && first_suspend_state_in;

    // RULE_03 mac filter, RULE_04 tcp syn check
    assign v6_frame_ok = (da_own || da_bcast || da_mcast)
                         && (rx_ethertype_in == `SWM_ETYPE_IPV6)
                         && (rx_ipv6_next_hdr_in == `SWM_NEXT_HDR_TCP)
                         && rx_tcp_valid_in && rx_tcp_syn_in;

    // RULE_05 header address compare, RULE_08 all-zero wildcard
    assign dst_ok = wild_match(st_q.dest, rx_ipv6_dst_in);
    assign src_ok = wild_match(v6_syn_source_match_in, rx_ipv6_src_in);

    // RULE_09 per-field port wildcards, only when ports apply
    assign ports_ok = !port_active
        || (wild_match({112'h0, st_q.ports[`SWM_PORT_DST_HI:`SWM_PORT_DST_LO]},
                       {112'h0, rx_tcp_dst_port_in})
            && wild_match({112'h0, st_q.ports[`SWM_PORT_SRC_HI:`SWM_PORT_SRC_LO]},
                          {112'h0, rx_tcp_src_port_in}));

    // RULE_06 all four matches gate the wake
    assign wake_hit = rx_frame_done_in && !rx_frame_error_in && v6_active
                      && v6_frame_ok && src_ok && dst_ok && ports_ok;

    // RULE_10 arp ethertype, RULE_11 own or broadcast only
    assign arp_frame_ok = st_q.ctrl[`SWM_CTRL_ARP_EN]
                          && (rx_ethertype_in == `SWM_ETYPE_ARP)
                          && (da_own || da_bcast);

    // RULE_12 spa/tpa compare, RULE_14 zero wildcard, RULE_16 first byte in 31:24
    assign arp_addr_ok = wild_match({96'h0, st_q.spa}, {96'h0, rx_arp_sender_ip_match_in})
                         && wild_match({96'h0, st_q.tpa}, {96'h0, rx_arp_target_ip_match_in});

    // RULE_13 response only for error-free frames
    assign arp_hit = rx_frame_done_in && !rx_frame_error_in && arp_frame_ok && arp_addr_ok;

    // RULE_15 read-only identification word
    assign phy_id_word = {PHY_REVISION, PHY_MODEL, PHY_OUI_BITS};

    assign bus_req  = avs_read_in || avs_write_in;
    assign bus_take = bus_req && !st_q.waitreq;

    // --------------------
    // next state
    // --------------------

    // bus slave, match pulses and interrupt status
    always_comb begin
        logic [31:0] rd;
        logic [1:0]  clr;
        logic [1:0]  set;
        rd  = `SWM_RESET_WORD;
        clr = 2'h0;
        set = 2'h0;
        st_d = st_q;

        // read mux, unmapped reads zero
        for (int i = 0; i < 4; i++) begin
            if (avs_address_in == `SWM_OFF_DEST0 + 12'(4 * i)) begin
                rd = st_q.dest[i];
            end
        end
        case (avs_address_in)
            `SWM_OFF_PORTS:   rd = st_q.ports;
            `SWM_OFF_ARP_SENDER_IP_MATCH: rd = st_q.spa;
            `SWM_OFF_ARP_TARGET_IP_MATCH: rd = st_q.tpa;
            `SWM_OFF_CTRL:    rd = {30'h0, st_q.ctrl};
            `SWM_OFF_STATUS:  rd = {30'h0, st_q.status};
            `SWM_OFF_MASK:    rd = {30'h0, st_q.mask};
            `SWM_OFF_PHY_ID:  rd = phy_id_word;
            default:          rd = rd;
        endcase

        // one wait cycle, then the access completes
        if (bus_req && st_q.waitreq) begin
            st_d.waitreq = 1'b0;
            st_d.rdata   = rd;
        end else begin
            st_d.waitreq = 1'b1;
        end

        // writes land on the completing edge
        if (bus_take && avs_write_in) begin
            // RULE_07 word i holds address bits 32*i+31:32*i
            for (int i = 0; i < 4; i++) begin
                if (avs_address_in == `SWM_OFF_DEST0 + 12'(4 * i)) begin
                    st_d.dest[i] = apply_be(st_q.dest[i], avs_writedata_in, avs_byteenable_in);
                end
            end
            case (avs_address_in)
                `SWM_OFF_PORTS:
                    st_d.ports = apply_be(st_q.ports, avs_writedata_in, avs_byteenable_in);
                `SWM_OFF_ARP_SENDER_IP_MATCH:
                    st_d.spa = apply_be(st_q.spa, avs_writedata_in, avs_byteenable_in);
                `SWM_OFF_ARP_TARGET_IP_MATCH:
                    st_d.tpa = apply_be(st_q.tpa, avs_writedata_in, avs_byteenable_in);
                `SWM_OFF_CTRL: begin
                    if (avs_byteenable_in[0]) begin
                        st_d.ctrl = avs_writedata_in[1:0];
                    end
                end
                `SWM_OFF_STATUS: begin
                    if (avs_byteenable_in[0]) begin
                        clr = avs_writedata_in[1:0];
                    end
                end
                `SWM_OFF_MASK: begin
                    if (avs_byteenable_in[0]) begin
                        st_d.mask = avs_writedata_in[1:0];
                    end
                end
                default: st_d.ctrl = st_d.ctrl;   // read-only and unmapped ignored
            endcase
        end

        // RULE_17 one pulse per matching frame
        st_d.wake = wake_hit;
        st_d.arp  = arp_hit;

        // sticky status, a new event beats a clear
        set[`SWM_EVT_WAKE] = wake_hit;
        set[`SWM_EVT_ARP]  = arp_hit;
        st_d.status = (st_q.status & ~clr) | set;
        st_d.irq    = |(st_d.status & st_d.mask);
    end

    // --------------------
    // state register
    // --------------------

    // all state in one flop group
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            st_q         <= '0;
            st_q.waitreq <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign avs_readdata_out    = st_q.rdata;
    assign avs_waitrequest_out = st_q.waitreq;
    assign wake_event_out      = st_q.wake;
    assign arp_respond_out     = st_q.arp;
    assign irq_out             = st_q.irq;

    // --------------------
    // checks
    // --------------------

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    // completing write cycle at a given offset
    sequence s_write_at(logic [11:0] off);
        avs_write_in && !avs_waitrequest_out && (avs_address_in == off)
            && (avs_byteenable_in == 4'hF);
    endsequence

    // read accepted into its wait cycle
    sequence s_read_phy;
        avs_read_in && avs_waitrequest_out && (avs_address_in == `SWM_OFF_PHY_ID);
    endsequence

    // RULE_01 wake only in the suspend window
    chk_wake_window: assert property (wake_event_out |-> $past(st_q.ctrl[0]) // RULE_01
        && ($past(first_suspend_state_in) || $past(third_suspend_state_in)))
        else $error("wake outside suspend window");

    // RULE_02 a mismatching source port blocks wake in first suspend
    chk_port_block: assert property (rx_frame_done_in && port_active // RULE_02
        && st_q.ports[15:0] != 16'h0 && st_q.ports[15:0] != rx_tcp_src_port_in
        |=> !wake_event_out)
        else $error("port mismatch woke");

    // RULE_03 mac destination qualification
    chk_wake_mac: assert property (wake_event_out // RULE_03
        |-> $past(da_own || da_bcast || da_mcast))
        else $error("wake for foreign mac");

    // RULE_04 only valid tcp syn segments
    chk_wake_syn: assert property (wake_event_out |-> $past(rx_tcp_syn_in) // RULE_04
        && $past(rx_tcp_valid_in) && $past(rx_ipv6_next_hdr_in) == `SWM_NEXT_HDR_TCP)
        else $error("wake without valid tcp syn");

    // RULE_06 all matches lead to wake next cycle
    chk_wake_fire: assert property (rx_frame_done_in && !rx_frame_error_in // RULE_06
        && v6_active && v6_frame_ok && src_ok && dst_ok && ports_ok |=> wake_event_out)
        else $error("matching syn no wake");

    // RULE_07 word one holds bits 63:32 of the destination value
    chk_dest_word: assert property (s_write_at(12'h6B0) // RULE_07
        |=> st_q.dest[1] == $past(avs_writedata_in))
        else $error("dest word one lost");

    // RULE_17 wake only after a frame end, none for errored frames
    chk_wake_clean: assert property (wake_event_out |-> $past(rx_frame_done_in) // RULE_17
        && !$past(rx_frame_error_in))
        else $error("wake without clean frame end");

    // RULE_10 arp response only for arp ethertype with offload on
    chk_arp_type: assert property (arp_respond_out // RULE_10
        |-> $past(rx_ethertype_in) == `SWM_ETYPE_ARP && $past(st_q.ctrl[1]))
        else $error("arp response for non-arp frame");

    // RULE_11 arp only for own or broadcast destination
    chk_arp_mac: assert property (arp_respond_out |-> $past(da_own || da_bcast)) // RULE_11
        else $error("arp for foreign mac");

    // RULE_13 qualified matching arp produces a response
    chk_arp_fire: assert property (rx_frame_done_in && !rx_frame_error_in // RULE_13
        && arp_frame_ok && arp_addr_ok |=> arp_respond_out)
        else $error("matching arp frame not answered");

    // RULE_12 programmed spa mismatch blocks the response
    chk_arp_sender_ip_match: assert property (rx_frame_done_in && st_q.spa != 32'h0 // RULE_12
        && st_q.spa != rx_arp_sender_ip_match_in |=> !arp_respond_out)
        else $error("arp answered despite spa mismatch");

    // RULE_15 identification reads its constant
    chk_phy_id: assert property (s_read_phy ##1 !avs_waitrequest_out // RULE_15
        |-> avs_readdata_out == phy_id_word)
        else $error("phy id read wrong");

    // interrupt rises only on an event or a mask write
    chk_irq_level: assert property ($rose(irq_out) |-> $past(wake_hit || arp_hit
        || (avs_write_in && avs_address_in == `SWM_OFF_MASK)))
        else $error("irq rose without cause");

endmodule

/* File: swm_mac_pm_model.sv */
// mac receive and power state model feeding the matcher
`timescale 1ns/1ps

module swm_mac_pm_model (
    input  wire logic         clk_sys_in,
    input  wire logic         wake_event_in,
    input  wire logic         arp_respond_in,
    output logic      [1:0]   power_state_out,
    output logic              rx_frame_done_out,
    output logic      [426:0] rx_fields_out
);

    // --------------------
    // idle values at time zero
    // --------------------
    initial begin
        power_state_out   = 2'h0;
        rx_frame_done_out = 1'b0;
        rx_fields_out     = '0;
    end

    // --------------------
    // one received frame, then the pulses it caused
    // --------------------
    // parsed header fields
    task automatic send(input logic [1:0] pw, input logic [426:0] f,
                        output logic wake, output logic arp, output logic late);
        @(posedge clk_sys_in);
        power_state_out   <= pw;
        rx_frame_done_out <= 1'b1;
        rx_fields_out     <= f;
        @(posedge clk_sys_in);
        rx_frame_done_out <= 1'b0;
        // fields only hold with done: show stale garbage after it
        rx_fields_out     <= ~f;
        @(negedge clk_sys_in);
        wake = wake_event_in;
        arp  = arp_respond_in;
        @(negedge clk_sys_in);
        late = wake_event_in | arp_respond_in;
    endtask

endmodule

/* File: swm_syn_wake_arp_match_tb_top.sv */
// self-checking bench of the syn wake / arp matcher
`timescale 1ns/1ps
`include "swm_params.svh"

module swm_syn_wake_arp_match_tb_top;

    // --------------------
    // signals and shadow state
    // --------------------
    typedef struct packed {
        logic         err;
        logic [47:0]  mac;
        logic [15:0]  etype;
        logic [7:0]   nh;
        logic [127:0] src;
        logic [127:0] dst;
        logic [15:0]  sport;
        logic [15:0]  dport;
        logic         syn;
        logic         vld;
        logic [31:0]  spa;
        logic [31:0]  tpa;
    } swm_frame_s;

    localparam logic [3:0]  REV   = 4'h3;       // arbitrary value
    localparam logic [5:0]  MODEL = 6'h15;      // arbitrary value
    localparam logic [21:0] OUI   = 22'h12_3456; // arbitrary value
    localparam logic [31:0] PHY_ID = {REV, MODEL, OUI};

    logic         clk_sys_in;
    logic         reset_in;
    logic [11:0]  addr;
    logic         rd_s;
    logic         wr_s;
    logic [31:0]  wdata;
    logic [3:0]   be;
    logic [31:0]  rdata;
    logic         waitreq;
    logic [47:0]  mac;
    logic [127:0] src_m;
    logic [1:0]   pw;
    logic         rx_done;
    swm_frame_s   rx_f;
    logic         wake;
    logic         arp;
    logic         irq;
    logic [127:0] dest;
    logic [31:0]  ports;
    logic [31:0]  spa;
    logic [31:0]  tpa;
    logic [1:0]   ctrl;
    int           fail_count = 0;
    int           samples_checked = 0;
    int           seed = 25;
    int           cycles = 0;

    swm_syn_wake_arp_match #(.PHY_REVISION(REV), .PHY_MODEL(MODEL), .PHY_OUI_BITS(OUI))
    swm_syn_wake_arp_match_i (
        .clk_sys_in             (clk_sys_in),
        .reset_in               (reset_in),
        .avs_address_in         (addr),
        .avs_read_in            (rd_s),
        .avs_write_in           (wr_s),
        .avs_writedata_in       (wdata),
        .avs_byteenable_in      (be),
        .avs_readdata_out       (rdata),
        .avs_waitrequest_out    (waitreq),
        .station_mac_in         (mac),
        .first_suspend_state_in (pw[0]),
        .third_suspend_state_in (pw[1]),
        .v6_syn_source_match_in (src_m),
        .rx_frame_done_in       (rx_done),
        .rx_frame_error_in      (rx_f.err),
        .rx_dest_mac_in         (rx_f.mac),
        .rx_ethertype_in        (rx_f.etype),
        .rx_ipv6_next_hdr_in    (rx_f.nh),
        .rx_ipv6_src_in         (rx_f.src),
        .rx_ipv6_dst_in         (rx_f.dst),
        .rx_tcp_src_port_in     (rx_f.sport),
        .rx_tcp_dst_port_in     (rx_f.dport),
        .rx_tcp_syn_in          (rx_f.syn),
        .rx_tcp_valid_in        (rx_f.vld),
        .rx_arp_sender_ip_match_in          (rx_f.spa),
        .rx_arp_target_ip_match_in          (rx_f.tpa),
        .wake_event_out         (wake),
        .arp_respond_out        (arp),
        .irq_out                (irq)
    );

    swm_mac_pm_model swm_mac_pm_model_i (
        .clk_sys_in        (clk_sys_in),
        .wake_event_in     (wake),
        .arp_respond_in    (arp),
        .power_state_out   (pw),
        .rx_frame_done_out (rx_done),
        .rx_fields_out     (rx_f)
    );

    // --------------------
    // clock, timeout and verdict
    // --------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard well above the expected some 1900 cycles
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // --------------------
    // compare, bus and expectation helpers
    // --------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] q);
        int n;
        @(posedge clk_sys_in);
        rd_s  <= !w;
        wr_s  <= w;
        addr  <= a;
        wdata <= d;
        be    <= b;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (waitreq !== 1'b0);
        q = rdata;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        chk("wait cycles", 32'h2, 32'(n));
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        chk($sformatf("reg %h", a), e, q);
    endtask

    task automatic irq_chk(input logic e);
        @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk("irq", 32'(e), 32'(irq));
    endtask

    task automatic program_regs();
        for (int i = 0; i < 4; i++) wr(`SWM_OFF_DEST0 + 12'(4 * i), dest[32 * i +: 32]);
        wr(`SWM_OFF_PORTS, ports);
        wr(`SWM_OFF_ARP_SENDER_IP_MATCH, spa);
        wr(`SWM_OFF_ARP_TARGET_IP_MATCH, tpa);
        wr(`SWM_OFF_CTRL, {30'h0, ctrl});
    endtask

    function automatic logic [127:0] pick(input logic [127:0] good);
        logic [127:0] r;
        r = {$random(seed), $random(seed), $random(seed), $random(seed)};
        return (r[127:125] == 3'h0) ? r : good;
    endfunction

    function automatic swm_frame_s rand_frame();
        swm_frame_s f;
        logic [7:0] k;
        k = 8'($random(seed));
        f.err   = (k[7:5] == 3'h0);
        f.mac   = k[1] ? (k[2] ? mac : `SWM_BCAST_MAC)
                       : (k[0] ? mac ^ 48'h1 : 48'h0100_0000_0000 | 48'(pick(0)));
        f.etype = 16'(pick(k[3] ? 128'(`SWM_ETYPE_IPV6) : 128'(`SWM_ETYPE_ARP)));
        f.nh    = 8'(pick(128'(`SWM_NEXT_HDR_TCP)));
        f.src   = pick(src_m);
        f.dst   = pick(dest);
        f.sport = 16'(pick(128'(ports[15:0])));
        f.dport = 16'(pick(128'(ports[31:16])));
        f.syn   = k[4] | (k[6:5] != 2'h0);
        f.vld   = 1'(pick(128'h1));
        f.spa   = 32'(pick(128'(spa)));
        f.tpa   = 32'(pick(128'(tpa)));
        return f;
    endfunction

    function automatic logic exp_wake(input swm_frame_s f, input logic [1:0] p);
        logic ok;
        ok = ctrl[0] && p != 2'h0 && !f.err && f.etype == `SWM_ETYPE_IPV6
             && (f.mac == mac || f.mac[`SWM_MCAST_BIT]) && f.nh == `SWM_NEXT_HDR_TCP
             && f.syn && f.vld && (src_m == '0 || src_m == f.src) && (dest == '0 || dest == f.dst);
        if (p[0]) ok = ok && (ports[31:16] == 16'h0 || ports[31:16] == f.dport)
                          && (ports[15:0] == 16'h0 || ports[15:0] == f.sport);
        return ok;
    endfunction

    function automatic logic exp_arp(input swm_frame_s f);
        return ctrl[1] && !f.err && f.etype == `SWM_ETYPE_ARP
               && (f.mac == mac || f.mac == `SWM_BCAST_MAC)
               && (spa == 32'h0 || spa == f.spa) && (tpa == 32'h0 || tpa == f.tpa);
    endfunction

    // --------------------
    // main sequence
    // --------------------
    initial begin
        swm_frame_s  f;
        logic        w;
        logic        a;
        logic        l;
        logic [1:0]  p;
        logic [31:0] q;
        reset_in = 1'b1;
        rd_s = 1'b0;
        wr_s = 1'b0;
        addr = 12'h0;
        wdata = 32'h0;
        be = 4'h0;
        mac = 48'h0200_0000_0001;
        src_m = '0;
        repeat (16) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        // reset values, read-only identity, unmapped place, lane enables
        for (int i = 0; i < 10; i++) rd_chk(`SWM_OFF_DEST0 + 12'(4 * i), 32'h0);
        rd_chk(`SWM_OFF_PHY_ID, PHY_ID);
        wr(`SWM_OFF_PHY_ID, 32'hFFFF_FFFF);
        rd_chk(`SWM_OFF_PHY_ID, PHY_ID);
        rd_chk(12'h6D4, 32'h0);
        bus(1'b1, `SWM_OFF_DEST0, 32'hA5A5_A5A5, 4'h1, q);
        rd_chk(`SWM_OFF_DEST0, 32'h0000_00A5);
        // random rounds of programmed values and frames, every enable code
        for (int r = 0; r < 8; r++) begin
            mac   <= 48'({$random(seed), $random(seed)}) & 48'hFEFF_FFFF_FFFF;
            src_m <= r[1] ? '0 : {$random(seed), $random(seed), $random(seed), $random(seed)};
            dest  = r[0] ? '0 : {$random(seed), $random(seed), $random(seed), $random(seed)};
            ports = {r[2] ? 16'h0 : 16'($random(seed)), r[1] ? 16'($random(seed)) : 16'h0};
            spa   = r[2] ? 32'($random(seed)) : 32'h0;
            tpa   = r[0] ? 32'($random(seed)) : 32'h0;
            ctrl  = 2'(r + 1);
            program_regs();
            for (int i = 0; i < 4; i++) rd_chk(`SWM_OFF_DEST0 + 12'(4 * i), dest[32 * i +: 32]);
            rd_chk(`SWM_OFF_PORTS, ports);
            for (int n = 0; n < 60; n++) begin
                f = rand_frame();
                p = 2'($random(seed));
                if (p == 2'h3) p = 2'h0;
                swm_mac_pm_model_i.send(p, f, w, a, l);
                chk("wake", 32'(exp_wake(f, p)), 32'(w));
                chk("arp", 32'(exp_arp(f)), 32'(a));
                chk("pulse end", 32'h0, 32'(l));
            end
        end
        // interrupt: sticky status, mask, write-one-to-clear
        dest = '0;
        ports = 32'h0;
        spa = 32'h0;
        tpa = 32'h0;
        ctrl = 2'h3;
        src_m <= '0;
        program_regs();
        wr(`SWM_OFF_STATUS, 32'h3);
        wr(`SWM_OFF_MASK, 32'h0);
        f = '0;
        f.mac = `SWM_BCAST_MAC;
        f.etype = `SWM_ETYPE_IPV6;
        f.nh = `SWM_NEXT_HDR_TCP;
        f.syn = 1'b1;
        f.vld = 1'b1;
        swm_mac_pm_model_i.send(2'h1, f, w, a, l);
        chk("wake", 32'h1, 32'(w));
        rd_chk(`SWM_OFF_STATUS, 32'h1);
        irq_chk(1'b0);
        wr(`SWM_OFF_MASK, 32'h1);
        irq_chk(1'b1);
        f.etype = `SWM_ETYPE_ARP;
        f.err = 1'b1;
        swm_mac_pm_model_i.send(2'h0, f, w, a, l);
        chk("arp", 32'h0, 32'(a));
        f.err = 1'b0;
        swm_mac_pm_model_i.send(2'h0, f, w, a, l);
        chk("arp", 32'h1, 32'(a));
        rd_chk(`SWM_OFF_STATUS, 32'h3);
        wr(`SWM_OFF_STATUS, 32'h1);
        rd_chk(`SWM_OFF_STATUS, 32'h2);
        irq_chk(1'b0);
        wr(`SWM_OFF_MASK, 32'h3);
        irq_chk(1'b1);
        wr(`SWM_OFF_STATUS, 32'h2);
        irq_chk(1'b0);
        report_and_stop();
    end

endmodule
